/* include/ssr_pkg.sv */
// constants and types shared by the security segment reassembler
package ssr_pkg;

   // ==========================================================
   // stream identity
   localparam logic [31:0] SSR_DST_ADDR     = 32'hEF00_3330;
   localparam logic [15:0] SSR_DST_PORT     = 16'h7572;
   localparam logic [6:0]  SSR_PT_AUTH      = 7'h4F;
   localparam logic [6:0]  SSR_PT_PUBKEY    = 7'h50;

   // ==========================================================
   // payload header
   localparam int          SSR_CNT_W        = 17;
   localparam logic [16:0] SSR_HDR_BYTES    = 17'h0_0004;
   localparam logic [16:0] SSR_LEN_KNOWN    = 17'h0_0002;
   localparam logic [3:0]  SSR_VER_MAJ_CUR  = 4'h0;

   // ==========================================================
   // register map (byte addresses)
   localparam logic [7:0]  SSR_REG_CTRL     = 8'h00;
   localparam logic [7:0]  SSR_REG_STATUS   = 8'h04;
   localparam logic [7:0]  SSR_REG_MASK     = 8'h08;
   localparam logic [7:0]  SSR_REG_INFO     = 8'h0C;
   localparam logic [7:0]  SSR_REG_COUNT    = 8'h10;

   localparam int          SSR_CTRL_EN      = 0;
   localparam int          SSR_CTRL_FLUSH   = 1;
   localparam logic        SSR_CTRL_EN_RST  = 1'b1;

   localparam int          SSR_EV_DONE      = 0;
   localparam int          SSR_EV_LOST      = 1;
   localparam int          SSR_EV_FMT       = 2;
   localparam int          SSR_EV_N         = 3;

   localparam int          SSR_INFO_LEN     = 0;
   localparam int          SSR_INFO_VMAJ    = 16;
   localparam int          SSR_INFO_VMIN    = 20;
   localparam int          SSR_INFO_TOK     = 24;
   localparam int          SSR_COUNT_DONE   = 0;
   localparam int          SSR_COUNT_LOST   = 16;

   typedef enum logic [1:0] {
      SSR_IDLE  = 2'b01,
      SSR_ACCUM = 2'b10
   } ssr_state_t;

endpackage

/* verilog/ssr_pkt_filter.sv */
// header filter: destination and payload type match for security segments
`timescale 1ns/1ps
module ssr_pkt_filter
   import ssr_pkg::*;
(
   input  wire logic [31:0] dstAddr,
   input  wire logic [15:0] dstPort,
   input  wire logic [6:0]  payloadType,
   input  wire logic        enable,
   output logic             accept,
   output logic             isPubKey
);

   logic typeOk;

   // ==========================================================
   // match
   assign typeOk   = (payloadType == SSR_PT_AUTH) || (payloadType == SSR_PT_PUBKEY);
   assign isPubKey = (payloadType == SSR_PT_PUBKEY);
   assign accept   = enable && typeOk
                     && (dstAddr == SSR_DST_ADDR) && (dstPort == SSR_DST_PORT);

endmodule

/* verilog/ssr_irq_status.sv */
// sticky event status, mask and level interrupt
`timescale 1ns/1ps
module ssr_irq_status
   import ssr_pkg::*;
#(
   parameter int N = SSR_EV_N
)(
   input  wire logic         clock,
   input  wire logic         rstn,
   input  wire logic [N-1:0] evSet,
   input  wire logic         clrWr,
   input  wire logic [N-1:0] clrBits,
   input  wire logic         maskWr,
   input  wire logic [N-1:0] maskBits,
   output logic      [N-1:0] status,
   output logic      [N-1:0] mask,
   output logic              irq
);

   logic [N-1:0] status_d;
   logic [N-1:0] mask_d;

   // ==========================================================
   // next values: a new event wins over a same-cycle clear
   always_comb begin
      status_d = (status & ~(clrWr ? clrBits : '0)) | evSet;
      mask_d   = maskWr ? maskBits : mask;
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         status <= '0;
         mask   <= '0;
         irq    <= 1'b0;
      end else begin
         status <= status_d;
         mask   <= mask_d;
         irq    <= |(status_d & mask_d);
      end
   end

endmodule

/* verilog/ssr_reassembler.sv */
// security segment reassembler: sequence check, accumulate, parse, forward
`timescale 1ns/1ps
module ssr_reassembler
   import ssr_pkg::*;
#(
   parameter int DEPTH = 4096
)(
   input  wire logic        clock,
   input  wire logic        rstn,
   // packet header, one-cycle strobe
   input  wire logic        pktStart,
   input  wire logic [31:0] pktDstAddr,
   input  wire logic [15:0] pktDstPort,
   input  wire logic        pktMarker,
   input  wire logic [6:0]  pktType,
   input  wire logic [15:0] pktSeq,
   // packet payload bytes
   input  wire logic        byteValid,
   input  wire logic [7:0]  byteData,
   input  wire logic        byteLast,
   // register port
   input  wire logic [7:0]  regAddr,
   input  wire logic [31:0] regWrData,
   input  wire logic        regWr,
   input  wire logic        regRd,
   output logic      [31:0] regRdData,
   // encrypted message bytes
   output logic             msgValid,
   output logic      [7:0]  msgData,
   output logic             msgFirst,
   output logic             msgLast,
   output logic             msgPubKey,
   output logic             irq
);

   localparam int          AW      = $clog2(DEPTH);
   localparam logic [16:0] DEPTH_C = 17'(DEPTH);

   // ==========================================================
   // declarations
   ssr_state_t            state_q;
   logic                  enable_q, pktTake_q, setPub_q;
   logic [15:0]           expSeq_q;
   logic [SSR_CNT_W-1:0]  wrCnt_q;
   logic [15:0]           len_q;
   logic [3:0]            vMaj_q, vMin_q;
   logic [7:0]            tok_q;
   logic [31:0]           info_q;
   logic [15:0]           doneCnt_q, lostCnt_q;
   logic                  fwdOn_q, fwdPub_q, pend_q, pendPub_q;
   logic [AW-1:0]         rdPtr_q, fwdEnd_q, pendEnd_q;
   logic [7:0]            mem [DEPTH];

   logic                  pass, isPub, hdrOk, accumOn, seqOk, startSet, contOk;
   logic                  lostEv, byteIn, endPkt, flush, fwdBusy;
   logic [SSR_CNT_W-1:0]  cntNext;
   logic [15:0]           lenCur;
   logic [3:0]            majCur, minCur;
   logic [7:0]            tokCur;
   logic                  lenKnown, complete, tooLong, badHdr, setOk, fmtErr, hasMsg;
   logic [AW-1:0]         endIdx;
   logic [SSR_EV_N-1:0]   evSet, status, mask;

   // ==========================================================
   // header filter
   ssr_pkt_filter u_filter (
      .dstAddr     (pktDstAddr),
      .dstPort     (pktDstPort),
      .payloadType (pktType),
      .enable      (enable_q),
      .accept      (pass),
      .isPubKey    (isPub)
   );

   // ==========================================================
   // set tracking
   assign hdrOk    = pktStart && pass;
   assign accumOn  = (state_q == SSR_ACCUM);
   assign seqOk    = (pktSeq == expSeq_q);
   assign startSet = hdrOk && pktMarker;
   assign contOk   = hdrOk && !pktMarker && accumOn && seqOk;
   // early marker or gap: whatever was gathered is gone
   assign lostEv   = hdrOk && accumOn && (pktMarker || !seqOk);
   assign byteIn   = byteValid && pktTake_q && accumOn;
   assign endPkt   = byteIn && byteLast;
   assign cntNext  = wrCnt_q + 17'h0_0001;
   assign flush    = regWr && (regAddr == SSR_REG_CTRL) && regWrData[SSR_CTRL_FLUSH];

   // header fields as they stand including the byte now arriving
   always_comb begin
      lenCur = len_q;
      majCur = vMaj_q;
      minCur = vMin_q;
      tokCur = tok_q;
      if (byteIn && wrCnt_q == 17'h0_0000) begin
         lenCur = {byteData, len_q[7:0]};
      end
      if (byteIn && wrCnt_q == 17'h0_0001) begin
         lenCur = {len_q[15:8], byteData};
      end
      if (byteIn && wrCnt_q == 17'h0_0002) begin
         majCur = byteData[7:4];
         minCur = byteData[3:0];
      end
      if (byteIn && wrCnt_q == 17'h0_0003) begin
         tokCur = byteData;
      end
   end

   // completion is judged at packet boundaries only
   assign lenKnown = cntNext >= SSR_LEN_KNOWN;
   assign complete = endPkt && lenKnown && (cntNext == {1'b0, lenCur});
   assign tooLong  = endPkt && lenKnown && (cntNext > {1'b0, lenCur});
   assign badHdr   = ({1'b0, lenCur} < SSR_HDR_BYTES)
                     || (majCur != SSR_VER_MAJ_CUR)
                     || (cntNext > DEPTH_C);
   assign setOk    = complete && !badHdr;
   assign fmtErr   = tooLong || (complete && badHdr);
   assign hasMsg   = {1'b0, lenCur} > SSR_HDR_BYTES;
   assign endIdx   = AW'(lenCur - 16'h0001);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         state_q <= SSR_IDLE;
      end else if (flush) begin
         state_q <= SSR_IDLE;
      end else if (startSet) begin
         state_q <= SSR_ACCUM;
      end else if (lostEv || complete || tooLong) begin
         state_q <= SSR_IDLE;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pktTake_q <= 1'b0;
      end else if (flush) begin
         pktTake_q <= 1'b0;
      end else if (hdrOk) begin
         pktTake_q <= startSet || contOk;
      end else if (byteValid && byteLast) begin
         pktTake_q <= 1'b0;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         expSeq_q <= '0;
         setPub_q <= 1'b0;
      end else if (startSet || contOk) begin
         expSeq_q <= pktSeq + 16'h0001;
         if (startSet) begin
            setPub_q <= isPub;
         end
      end
   end

   // ==========================================================
   // accumulation and header capture
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         wrCnt_q <= '0;
         len_q   <= '0;
         vMaj_q  <= '0;
         vMin_q  <= '0;
         tok_q   <= '0;
      end else if (startSet) begin
         wrCnt_q <= '0;
      end else if (byteIn) begin
         if (!(&wrCnt_q)) begin
            wrCnt_q <= cntNext;
         end
         len_q  <= lenCur;
         vMaj_q <= majCur;
         vMin_q <= minCur;
         tok_q  <= tokCur;
      end
   end

   // writes trail the forward read pointer, so a new set may fill behind it
   always_ff @(posedge clock) begin
      if (byteIn && (wrCnt_q < DEPTH_C)) begin
         mem[wrCnt_q[AW-1:0]] <= byteData;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         info_q    <= '0;
         doneCnt_q <= '0;
         lostCnt_q <= '0;
      end else begin
         if (setOk) begin
            info_q <= {tokCur, minCur, majCur, lenCur};
            doneCnt_q <= doneCnt_q + 16'h0001;
         end
         if (lostEv) begin
            lostCnt_q <= lostCnt_q + 16'h0001;
         end
      end
   end

   // ==========================================================
   // forwarding of encrypted message bytes
   // a set finishing while another is still streaming waits one slot;
   // a third set finishing meanwhile replaces the waiting one
   // a run in its final byte with nothing waiting counts as free
   assign fwdBusy = fwdOn_q && ((rdPtr_q != fwdEnd_q) || pend_q);

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         fwdOn_q   <= 1'b0;
         rdPtr_q   <= '0;
         fwdEnd_q  <= '0;
         fwdPub_q  <= 1'b0;
         pend_q    <= 1'b0;
         pendEnd_q <= '0;
         pendPub_q <= 1'b0;
      end else begin
         if (fwdOn_q && rdPtr_q != fwdEnd_q) begin
            rdPtr_q <= rdPtr_q + AW'(1);
         end else if (fwdOn_q && pend_q) begin
            rdPtr_q  <= AW'(SSR_HDR_BYTES);
            fwdEnd_q <= pendEnd_q;
            fwdPub_q <= pendPub_q;
            pend_q   <= 1'b0;
         end else if (fwdOn_q) begin
            fwdOn_q <= 1'b0;
         end
         if (setOk && hasMsg) begin
            if (fwdBusy) begin
               pend_q    <= 1'b1;
               pendEnd_q <= endIdx;
               pendPub_q <= setPub_q;
            end else begin
               fwdOn_q  <= 1'b1;
               rdPtr_q  <= AW'(SSR_HDR_BYTES);
               fwdEnd_q <= endIdx;
               fwdPub_q <= setPub_q;
            end
         end
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         msgValid  <= 1'b0;
         msgFirst  <= 1'b0;
         msgLast   <= 1'b0;
         msgPubKey <= 1'b0;
      end else begin
         msgValid  <= fwdOn_q;
         msgFirst  <= fwdOn_q && (rdPtr_q == AW'(SSR_HDR_BYTES));
         msgLast   <= fwdOn_q && (rdPtr_q == fwdEnd_q);
         msgPubKey <= fwdPub_q;
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         msgData <= '0;
      end else if (fwdOn_q) begin
         msgData <= mem[rdPtr_q];
      end
   end

   // ==========================================================
   // events and interrupt
   always_comb begin
      evSet              = '0;
      evSet[SSR_EV_DONE] = setOk;
      evSet[SSR_EV_LOST] = lostEv;
      evSet[SSR_EV_FMT]  = fmtErr;
   end

   ssr_irq_status #(.N(SSR_EV_N)) u_irq (
      .clock    (clock),
      .rstn     (rstn),
      .evSet    (evSet),
      .clrWr    (regWr && regAddr == SSR_REG_STATUS),
      .clrBits  (regWrData[SSR_EV_N-1:0]),
      .maskWr   (regWr && regAddr == SSR_REG_MASK),
      .maskBits (regWrData[SSR_EV_N-1:0]),
      .status   (status),
      .mask     (mask),
      .irq      (irq)
   );

   // ==========================================================
   // register port
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         enable_q <= SSR_CTRL_EN_RST;
      end else if (regWr && regAddr == SSR_REG_CTRL) begin
         enable_q <= regWrData[SSR_CTRL_EN];
      end
   end

   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         regRdData <= '0;
      end else if (regRd) begin
         unique case (regAddr)
            SSR_REG_CTRL:   regRdData <= {29'h0, accumOn, 1'b0, enable_q};
            SSR_REG_STATUS: regRdData <= {29'h0, status};
            SSR_REG_MASK:   regRdData <= {29'h0, mask};
            SSR_REG_INFO:   regRdData <= info_q;
            SSR_REG_COUNT:  regRdData <= {lostCnt_q, doneCnt_q};
            default:        regRdData <= '0;
         endcase
      end else begin
         regRdData <= '0;
      end
   end

endmodule

/* sim/ssr_reassembler_checker.sv */
// concurrent checks on the reassembler ports
`timescale 1ns/1ps
module ssr_reassembler_checker
   import ssr_pkg::*;
(
   input wire logic        clock,
   input wire logic        rstn,
   input wire logic        byteValid,
   input wire logic        byteLast,
   input wire logic [7:0]  regAddr,
   input wire logic [31:0] regWrData,
   input wire logic        regWr,
   input wire logic        regRd,
   input wire logic [31:0] regRdData,
   input wire logic        msgValid,
   input wire logic        msgFirst,
   input wire logic        msgLast,
   input wire logic        msgPubKey,
   input wire logic        irq
);
   // ==========
   // helpers
   logic lastByte;
   assign lastByte = byteValid & byteLast;
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rstn);

   // ==========
   // register port
   rd_idle_zero_a: assert property (!regRd |=> regRdData == 32'h0000_0000)
      else $error("read data not zero outside a read answer");
   unmapped_rd_a: assert property (regRd && regAddr == 8'h14 |=> regRdData == 32'h0000_0000)
      else $error("unmapped read returned data");
   irq_mask_off_a: assert property ((regWr && regAddr == SSR_REG_MASK && regWrData[2:0] == 3'h0)
      ##1 !(regWr && regAddr == SSR_REG_MASK) |=> !irq)
      else $error("irq high with all events masked");

   // ==========
   // message output
   msg_first_rise_a: assert property ($rose(msgValid) |-> msgFirst)
      else $error("message run without first flag");
   msg_flag_valid_a: assert property ((msgFirst || msgLast) |-> msgValid)
      else $error("first or last flag without valid");
   msg_run_a: assert property (msgValid && !msgLast |=> msgValid && !msgFirst)
      else $error("message run broken before last byte");
   msg_restart_a: assert property (msgLast |=> !msgValid || msgFirst)
      else $error("bytes after last without new first");
   msg_start_lat_a: assert property (msgFirst && !$past(msgValid) |-> $past(lastByte, 2))
      else $error("forward did not start two cycles after completion");
   pub_stable_a: assert property (msgValid && !msgFirst |-> $stable(msgPubKey))
      else $error("payload kind changed inside a message");

   cover property (msgValid && msgLast);
   cover property ($rose(irq));
   cover property (regRd && regAddr == SSR_REG_COUNT);
endmodule

bind ssr_reassembler ssr_reassembler_checker ssrChk (
   .clock(clock), .rstn(rstn), .byteValid(byteValid), .byteLast(byteLast),
   .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
   .regRdData(regRdData), .msgValid(msgValid), .msgFirst(msgFirst),
   .msgLast(msgLast), .msgPubKey(msgPubKey), .irq(irq)
);

/* sim/ssr_gateway_model.sv */
// gateway model: sends security segments into the reassembler
`timescale 1ns/1ps
module ssr_gateway_model
   import ssr_pkg::*;
(
   input  wire logic        clock,
   output logic             pktStart,
   output logic      [31:0] pktDstAddr,
   output logic      [15:0] pktDstPort,
   output logic             pktMarker,
   output logic      [6:0]  pktType,
   output logic      [15:0] pktSeq,
   output logic             byteValid,
   output logic      [7:0]  byteData,
   output logic             byteLast
);
   // ==========
   // segment sender
   // header bits with no port: extension 0, no sources, one timestamp, source 0
   logic [7:0] mem [0:127];
   int         gap = 0;

   initial begin
      {pktStart, pktMarker, byteValid, byteLast} = 4'h0;
      {pktDstAddr, pktDstPort, pktType, pktSeq, byteData} = '0;
   end

   task automatic sendSeg(input logic mk, input logic [6:0] pt, input logic [31:0] a,
                          input logic [15:0] pn, input logic [15:0] sq, input int f, n);
      @(posedge clock);
      pktStart   <= 1'b1;
      pktMarker  <= mk;
      pktType    <= pt;
      pktDstAddr <= a;
      pktDstPort <= pn;
      pktSeq     <= sq;
      for (int i = 0; i < n; i++) begin
         @(posedge clock);
         pktStart  <= 1'b0;
         byteValid <= 1'b1;
         byteData  <= mem[f+i];
         byteLast  <= (i == n - 1);
         if (gap != 0 && i != n - 1) begin
            @(posedge clock);
            byteValid <= 1'b0;
            byteData  <= ~byteData;
         end
      end
      // released byte, sequence and destination address lines never keep their last value
      @(posedge clock);
      {byteValid, byteLast} <= 2'h0;
      byteData   <= ~byteData;
      pktSeq     <= ~pktSeq;
      pktDstAddr <= ~pktDstAddr;
   endtask
endmodule

/* sim/security_stream_segment_reassembler_bench.sv */
// self-checking bench for the security segment reassembler
`timescale 1ns/1ps
module security_stream_segment_reassembler_bench
   import ssr_pkg::*;
;
   logic        clock, rstn, regWr, regRd, pktStart, pktMarker, byteValid, byteLast;
   logic [7:0]  regAddr, byteData;
   logic [31:0] regWrData, regRdData, pktDstAddr;
   logic [15:0] pktDstPort, pktSeq, seq;
   logic [6:0]  pktType;
   logic        msgValid, msgFirst, msgLast, msgPubKey, irq, expPub;
   logic [7:0]  msgData;
   logic [3:0]  mnr;
   logic [2:0]  maskV;
   logic [7:0]  got [$];
   int          n_mismatch, total_checks, nDone, nLost, expN;
   int          seed = 48179;

   ssr_reassembler #(.DEPTH(64)) dut (
      .clock(clock), .rstn(rstn), .pktStart(pktStart), .pktDstAddr(pktDstAddr),
      .pktDstPort(pktDstPort), .pktMarker(pktMarker), .pktType(pktType), .pktSeq(pktSeq),
      .byteValid(byteValid), .byteData(byteData), .byteLast(byteLast), .regAddr(regAddr),
      .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
      .msgValid(msgValid), .msgData(msgData), .msgFirst(msgFirst), .msgLast(msgLast),
      .msgPubKey(msgPubKey), .irq(irq));
   ssr_gateway_model gw (
      .clock(clock), .pktStart(pktStart), .pktDstAddr(pktDstAddr), .pktDstPort(pktDstPort),
      .pktMarker(pktMarker), .pktType(pktType), .pktSeq(pktSeq), .byteValid(byteValid),
      .byteData(byteData), .byteLast(byteLast));

   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end

   // ==========
   // checking and bus tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic end_of_test();
      $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      {regWr, regAddr, regWrData} <= {1'b1, a, d};
      @(posedge clock);
      regWr <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      @(posedge clock);
      {regRd, regAddr} <= {1'b1, a};
      @(posedge clock);
      regRd <= 1'b0;
      #1 chk(regRdData, e);
   endtask

   // collector: first and last flags expected from the byte position in the message, kind flag from the payload type
   always @(posedge clock) begin
      if (msgValid === 1'b1) begin
         chk({msgFirst, msgLast, msgPubKey}, {got.size() == 0, got.size() == expN - 1, expPub});
         got.push_back(msgData);
      end
   end

   // ==========
   // set builder, sender and expectation
   task automatic sendSet(input int tot, nseg, drop, input logic [6:0] pt,
                          input logic [31:0] a, input logic [15:0] pn);
      int per;
      int f;
      per = (tot + nseg - 1) / nseg;
      for (int k = 0; k < nseg; k++) begin
         f = k * per;
         if (f >= tot || (drop == 2 && k == 1))
            break;
         if (drop == 1 && k == 1)
            seq++;
         gw.sendSeg(k == 0, pt, a, pn, seq, f, (tot - f < per) ? tot - f : per);
         seq++;
      end
   endtask

   task automatic run(input int len, tot, nseg, input logic [3:0] maj, input logic [7:0] tok,
                      input logic [6:0] pt, input int n, input logic [2:0] st,
                      input int drop = 0, input logic [31:0] a = SSR_DST_ADDR,
                      input logic [15:0] pn = SSR_DST_PORT);
      int w;
      mnr = 4'($random(seed));
      {gw.mem[0], gw.mem[1], gw.mem[2], gw.mem[3]} = {len[15:0], maj, mnr, tok};
      for (int i = 4; i < tot; i++)
         gw.mem[i] = 8'($random(seed));
      expN = n;
      expPub = (pt == SSR_PT_PUBKEY);
      got.delete();
      sendSet(tot, nseg, drop, pt, a, pn);
      w = 0;
      while (got.size() < n && w < 300) begin
         @(posedge clock);
         w++;
      end
      if (w == 300) begin
         n_mismatch++;
         end_of_test();
      end
      repeat (4) @(posedge clock);
      chk(got.size(), n);
      foreach (got[i])
         chk(got[i], gw.mem[i+4]);
      rc(SSR_REG_STATUS, {29'h0, st});
      chk(irq, |(st & maskV));
      if (st[0])
         rc(SSR_REG_INFO, {tok, mnr, maj, len[15:0]});
      nDone += st[0];
      nLost += st[1];
      wr(SSR_REG_STATUS, 32'h0000_0007);
      @(posedge clock);
      #1 chk(irq, 1'b0);
      $display("test done len=%0d status=%h", len, st);
   endtask

   // ==========
   // main sequence
   initial begin
      int len;
      {rstn, regWr, regRd, regAddr, regWrData} = '0;
      {seq, maskV, n_mismatch, total_checks, nDone, nLost, expN, expPub} = '0;
      repeat (5) @(posedge clock);
      rstn <= 1'b1;
      rc(SSR_REG_CTRL, 32'h0000_0001);
      rc(SSR_REG_STATUS, 32'h0000_0000);
      rc(SSR_REG_MASK, 32'h0000_0000);
      rc(8'h14, 32'h0000_0000);
      $display("test done reset values");
      run(6, 6, 1, 4'h0, 8'h00, SSR_PT_AUTH, 2, 3'h1);
      for (int k = 0; k < 6; k++) begin
         gw.gap = k % 2;
         len = 5 + ($random(seed) & 31);
         run(len, len, 1 + k % 4, 4'h0, 8'($random(seed)),
             (k % 2) ? SSR_PT_PUBKEY : SSR_PT_AUTH, len - 4, 3'h1);
      end
      gw.gap = 0;
      run(4, 4, 1, 4'h0, 8'hFF, SSR_PT_AUTH, 0, 3'h1);
      run(64, 64, 3, 4'h0, 8'h00, SSR_PT_PUBKEY, 60, 3'h1);
      run(65, 65, 3, 4'h0, 8'h01, SSR_PT_AUTH, 0, 3'h4);
      run(20, 20, 3, 4'h0, 8'h02, SSR_PT_AUTH, 0, 3'h2, 1);
      run(20, 20, 3, 4'h0, 8'h03, SSR_PT_AUTH, 0, 3'h0, 2);
      run(12, 12, 2, 4'h0, 8'h04, SSR_PT_AUTH, 8, 3'h3);
      run(10, 10, 2, 4'h3, 8'h05, SSR_PT_AUTH, 0, 3'h4);
      run(10, 13, 2, 4'h0, 8'h06, SSR_PT_AUTH, 0, 3'h4);
      for (int i = 0; i < 4; i++) begin
         if (i == 3)
            wr(SSR_REG_CTRL, 32'h0000_0000);
         run(8, 8, 1, 4'h0, 8'h07, (i == 2) ? 7'h51 : SSR_PT_AUTH, 0, 3'h0, 0,
             SSR_DST_ADDR ^ 32'(i == 0), SSR_DST_PORT ^ 16'(i == 1));
      end
      wr(SSR_REG_CTRL, 32'h0000_0001);
      // high length byte set: six bytes leave the set open until flushed
      run(16'h0106, 6, 1, 4'h0, 8'h09, SSR_PT_AUTH, 0, 3'h0);
      rc(SSR_REG_CTRL, 32'h0000_0005);
      wr(SSR_REG_CTRL, 32'h0000_0003);
      rc(SSR_REG_CTRL, 32'h0000_0001);
      run(8, 8, 1, 4'h0, 8'h0A, SSR_PT_AUTH, 4, 3'h1);
      maskV = 3'h7;
      wr(SSR_REG_MASK, 32'h0000_0007);
      rc(SSR_REG_MASK, 32'h0000_0007);
      run(8, 8, 2, 4'h0, 8'h08, SSR_PT_PUBKEY, 4, 3'h1);
      maskV = 3'h0;
      wr(SSR_REG_MASK, 32'h0000_0000);
      rc(SSR_REG_COUNT, {nLost[15:0], nDone[15:0]});
      end_of_test();
   end
endmodule
